// ===== src/aesp_pkg.sv
package aesp_pkg;

    // Operand and result widths of the datapath.
    localparam int STATE_W = 128;
    localparam int WORD_W  = 32;
    localparam int CLMUL_W = 64;

    // Cycles from an accepted operand set to its result.
    localparam int LATENCY = 1;

    // Feature word: positions of the capability flags and the value after reset.
    localparam int          FEAT_AES_BIT   = 25;
    localparam int          FEAT_CLMUL_BIT = 1;
    localparam logic [31:0] FEATURE_WORD   = 32'h0200_0002;

    // Field constants: low byte of the reduction polynomial and the affine offsets.
    localparam logic [7:0] GF_POLY_LOW   = 8'h1B;
    localparam logic [7:0] SBOX_AFFINE   = 8'h63;
    localparam logic [7:0] INV_AFFINE    = 8'h05;
    localparam logic [7:0] INV_SBOX_ZERO = 8'h52;

    // Column coefficients, byte 0 is the one applied to the diagonal input row.
    localparam logic [31:0] MIX_COEF     = 32'h0101_0302;
    localparam logic [31:0] INV_MIX_COEF = 32'h090D_0B0E;

    // Value of the result register after reset.
    localparam logic [127:0] RESULT_RESET = 128'h0;

    // Operation select of the pipeline.
    typedef enum logic [2:0] {
        OP_SUB_BYTES      = 3'h0,
        OP_INV_SUB_BYTES  = 3'h1,
        OP_SHIFT_ROWS     = 3'h2,
        OP_INV_SHIFT_ROWS = 3'h3,
        OP_MIX_COLS       = 3'h4,
        OP_INV_MIX_COLS   = 3'h5,
        OP_SUB_WORD       = 3'h6,
        OP_CLMUL          = 3'h7
    } aesp_op_e;

    // Multiplies a field element by x and reduces it.
    function automatic logic [7:0] gf_xtime(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY_LOW : 8'h00);
    endfunction

    // Carry-less product of two bytes reduced on the fly; addition is XOR.
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h00;
        p = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                r = r ^ p;
            end
            p = gf_xtime(p);
        end
        return r;
    endfunction

    // Multiplicative inverse as a to the power 254; zero maps to zero.
    function automatic logic [7:0] gf_inv(input logic [7:0] a);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h01;
        p = a;
        for (int i = 1; i < 8; i++) begin
            p = gf_mul(p, p);
            r = gf_mul(r, p);
        end
        return r;
    endfunction

    // Rotates a byte left by n bit positions.
    function automatic logic [7:0] rotl8(input logic [7:0] x, input int n);
        logic [15:0] t;
        t = {x, x} << n;
        return t[15:8];
    endfunction

    // Forward substitution value of one byte.
    function automatic logic [7:0] sbox_fwd(input logic [7:0] x);
        logic [7:0] v;
        v = gf_inv(x);
        return v ^ rotl8(v, 1) ^ rotl8(v, 2) ^ rotl8(v, 3) ^ rotl8(v, 4) ^ SBOX_AFFINE;
    endfunction

    // Inverse substitution value of one byte.
    function automatic logic [7:0] sbox_inv(input logic [7:0] x);
        return gf_inv(rotl8(x, 1) ^ rotl8(x, 3) ^ rotl8(x, 6) ^ INV_AFFINE);
    endfunction

endpackage

// ===== src/aesp_sbox_word.sv
// Substitutes the four bytes of a word in place, forward or inverse.
module aesp_sbox_word
    import aesp_pkg::*;
(
    // Operand.
    input  wire logic [aesp_pkg::WORD_W-1:0] word_i,
    input  wire logic                        inverse_i,
    // Result.
    output logic      [aesp_pkg::WORD_W-1:0] word_o
);

    // Each byte is looked up on its own and keeps its lane.
    always_comb begin
        word_o = '0;
        for (int b = 0; b < 4; b++) begin
            word_o[8*b +: 8] = inverse_i ? sbox_inv(word_i[8*b +: 8]) : sbox_fwd(word_i[8*b +: 8]);
        end
    end

endmodule

// ===== src/aesp_clmul64.sv
// Full carry-less product of two 64-bit polynomials, no reduction.
module aesp_clmul64
    import aesp_pkg::*;
(
    // Operands.
    input  wire logic [aesp_pkg::CLMUL_W-1:0]   a_i,
    input  wire logic [aesp_pkg::CLMUL_W-1:0]   b_i,
    // Product.
    output logic      [2*aesp_pkg::CLMUL_W-1:0] prod_o
);

    // Shifted copies of a are summed by XOR wherever b has a one.
    always_comb begin
        prod_o = '0;
        for (int i = 0; i < CLMUL_W; i++) begin
            if (b_i[i]) begin
                prod_o = prod_o ^ ({{CLMUL_W{1'b0}}, a_i} << i);
            end
        end
    end

endmodule

// ===== src/aesp_round_prims.sv
// Functional notes
// - Forward substitution maps every state byte through the fixed nonlinear table, so byte 00 becomes 63.
// - Word substitution passes each of the four bytes of a word through the forward table in its own lane.
// - Inverse column mix forms output row 0 as 0e, 0b, 0d and 09 times input rows 0 to 3, XORed together.
// - Output rows 1 to 3 of the inverse mix rotate that coefficient sequence right by one per row, in every column.
// - Inverse column mix exactly undoes the forward column mix on the whole state.
// - Inverse row shift keeps row 0 and rotates rows 1, 2 and 3 right by one, two and three bytes.
// - Inverse substitution maps every byte through the inverse table, so byte 00 becomes 52.
// - Inverse substitution undoes forward substitution for all 256 byte values.
// - The carry-less multiplier gives the full 128-bit XOR polynomial product of two 64-bit operands.
// - The feature word reports AES support in bit 25 and carry-less multiply support in bit 1.
// - Field multiplication is a carry-less byte product reduced by the degree-8 polynomial, and addition is XOR.
// - Forward column mix forms row 0 as 02, 03, 01, 01 times rows 0 to 3, rotated right per later row.
// - Forward row shift keeps row 0 and rotates rows 1, 2 and 3 left by one, two and three bytes.
// - State byte k sits at row k mod 4 and column k div 4, so each column is one 32-bit word.
module aesp_round_prims
    import aesp_pkg::*;
(
    // Clock and reset.
    input  wire logic                         clock_i,
    input  wire logic                         reset_n_i,
    // Operand set from the pipeline.
    input  wire logic                         valid_i,
    input  wire aesp_pkg::aesp_op_e           op_i,
    input  wire logic [aesp_pkg::STATE_W-1:0] state_i,
    // Result to the pipeline.
    output logic                              valid_o,
    output logic      [aesp_pkg::STATE_W-1:0] result_o,
    // Capability flags for the feature query.
    output logic      [31:0]                  feature_o
);

    // Registered state of the result stage.
    typedef struct packed {
        logic               valid;
        logic [STATE_W-1:0] result;
        logic [31:0]        feature;
    } aesp_stage_s;

    aesp_stage_s          stage_q;
    aesp_stage_s          stage_d;
    logic [STATE_W-1:0]   sub_state;
    logic [2*CLMUL_W-1:0] clmul_prod;
    logic                 sub_inverse;

    // Reads byte k of the state.
    function automatic logic [7:0] get_byte(input logic [STATE_W-1:0] s, input int row, input int col);
        return s[8*(4*col+row) +: 8];
    endfunction

    // Permutes rows; row r moves left by r positions, or right when inverse.
    function automatic logic [STATE_W-1:0] shift_rows(input logic [STATE_W-1:0] s, input logic inverse);
        logic [STATE_W-1:0] r;
        int                 src;
        r   = '0;
        src = 0;
        for (int col = 0; col < 4; col++) begin
            for (int row = 0; row < 4; row++) begin
                src = inverse ? (col + 4 - row) % 4 : (col + row) % 4;
                r[8*(4*col+row) +: 8] = get_byte(s, row, src);
            end
        end
        return r;
    endfunction

    // rotated coefficients, field products.
    // Mixes one column word with a coefficient set rotated right per output row.
    function automatic logic [WORD_W-1:0] mix_word(input logic [WORD_W-1:0] w, input logic [31:0] coef);
        logic [WORD_W-1:0] r;
        r = '0;
        for (int row = 0; row < 4; row++) begin
            for (int j = 0; j < 4; j++) begin
                r[8*row +: 8] = r[8*row +: 8] ^ gf_mul(coef[8*((j + 4 - row) % 4) +: 8], w[8*j +: 8]);
            end
        end
        return r;
    endfunction

    // Mixes all four columns of the state.
    function automatic logic [STATE_W-1:0] mix_cols(input logic [STATE_W-1:0] s, input logic inverse);
        logic [STATE_W-1:0] r;
        r = '0;
        for (int col = 0; col < 4; col++) begin
            r[WORD_W*col +: WORD_W] = mix_word(s[WORD_W*col +: WORD_W], inverse ? INV_MIX_COEF : MIX_COEF);
        end
        return r;
    endfunction

    // Substitutes all sixteen bytes, used to check the lookup lanes.
    function automatic logic [STATE_W-1:0] sub_all(input logic [STATE_W-1:0] s, input logic inverse);
        logic [STATE_W-1:0] r;
        r = '0;
        for (int k = 0; k < 16; k++) begin
            r[8*k +: 8] = inverse ? sbox_inv(s[8*k +: 8]) : sbox_fwd(s[8*k +: 8]);
        end
        return r;
    endfunction

    // The lookup lanes run inverse only for the inverse substitution.
    assign sub_inverse = (op_i == OP_INV_SUB_BYTES);

    // one column word per lookup lane.
    for (genvar g = 0; g < 4; g++) begin : g_lane
        aesp_sbox_word u_sbox (
            .word_i    (state_i[WORD_W*g +: WORD_W]),
            .inverse_i (sub_inverse),
            .word_o    (sub_state[WORD_W*g +: WORD_W])
        );
    end

    aesp_clmul64 u_clmul (
        .a_i    (state_i[CLMUL_W-1:0]),
        .b_i    (state_i[STATE_W-1:CLMUL_W]),
        .prod_o (clmul_prod)
    );

    // Next value of the stage: a valid operand set loads a new result, otherwise it holds.
    always_comb begin
        stage_d         = stage_q;
        // one operand set per valid cycle.
        stage_d.valid   = valid_i;
        stage_d.feature = FEATURE_WORD;
        if (valid_i) begin
            case (op_i)
                OP_SUB_BYTES: begin
                    stage_d.result = sub_state;
                end
                OP_INV_SUB_BYTES: begin
                    stage_d.result = sub_state;
                end
                OP_SHIFT_ROWS: begin
                    stage_d.result = shift_rows(state_i, 1'b0);
                end
                OP_INV_SHIFT_ROWS: begin
                    stage_d.result = shift_rows(state_i, 1'b1);
                end
                OP_MIX_COLS: begin
                    stage_d.result = mix_cols(state_i, 1'b0);
                end
                OP_INV_MIX_COLS: begin
                    stage_d.result = mix_cols(state_i, 1'b1);
                end
                // low word substituted in place, upper words cleared.
                OP_SUB_WORD: begin
                    stage_d.result = {{(STATE_W-WORD_W){1'b0}}, sub_state[WORD_W-1:0]};
                end
                OP_CLMUL: begin
                    stage_d.result = clmul_prod;
                end
                default: begin
                    stage_d.result = RESULT_RESET;
                end
            endcase
        end
    end

    // the stage register; reset clears valid and result and loads the feature word.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_q <= '{valid: 1'b0, result: RESULT_RESET, feature: FEATURE_WORD};
        end else begin
            stage_q <= stage_d;
        end
    end

    // Outputs come straight from the stage register.
    assign valid_o   = stage_q.valid;
    assign result_o  = stage_q.result;
    assign feature_o = stage_q.feature;

    // Checks run on the core clock and pause during reset.
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    // An operand set of a given kind accepted in this cycle.
    sequence s_take(aesp_op_e op);
        valid_i && op_i == op;
    endsequence

    // A valid result of any kind is presented in the next cycle.
    sequence s_give;
        ##1 valid_o;
    endsequence

    // Zero in, all 63 out.
    a_sub_zero: assert property (s_take(OP_SUB_BYTES) and state_i == '0 |=> result_o == {16{SBOX_AFFINE}})
        else $error("forward substitution of zero is wrong");

    // Each byte of the result is the forward table value.
    a_sub_lanes: assert property (s_take(OP_SUB_BYTES) |=> result_o == sub_all($past(state_i), 1'b0))
        else $error("forward substitution lanes are wrong");

    // Word substitution keeps lanes and clears the upper words.
    a_word_lanes: assert property (s_take(OP_SUB_WORD) |=>
        result_o == (sub_all($past(state_i), 1'b0) & {96'h0, 32'hFFFF_FFFF}))
        else $error("word substitution is wrong");

    // Inverse row 0 uses 0e, 0b, 0d, 09.
    a_imix_row0: assert property (s_take(OP_INV_MIX_COLS) |=> result_o[7:0] ==
        (gf_mul(8'h0E, $past(state_i[7:0])) ^ gf_mul(8'h0B, $past(state_i[15:8]))
        ^ gf_mul(8'h0D, $past(state_i[23:16])) ^ gf_mul(8'h09, $past(state_i[31:24]))))
        else $error("inverse mix row 0 is wrong");

    // Inverse row 1 of the last column uses the sequence rotated by one.
    a_imix_row1: assert property (s_take(OP_INV_MIX_COLS) |=> result_o[111:104] ==
        (gf_mul(8'h09, $past(state_i[103:96])) ^ gf_mul(8'h0E, $past(state_i[111:104]))
        ^ gf_mul(8'h0B, $past(state_i[119:112])) ^ gf_mul(8'h0D, $past(state_i[127:120]))))
        else $error("inverse mix row 1 is wrong");

    // Inverse row 2 of column 1 uses the sequence rotated by two.
    a_imix_row2: assert property (s_take(OP_INV_MIX_COLS) |=> result_o[55:48] ==
        (gf_mul(8'h0D, $past(state_i[39:32])) ^ gf_mul(8'h09, $past(state_i[47:40]))
        ^ gf_mul(8'h0E, $past(state_i[55:48])) ^ gf_mul(8'h0B, $past(state_i[63:56]))))
        else $error("inverse mix row 2 is wrong");

    // Inverse row 3 of column 0 uses the sequence rotated by three.
    a_imix_row3: assert property (s_take(OP_INV_MIX_COLS) |=> result_o[31:24] ==
        (gf_mul(8'h0B, $past(state_i[7:0])) ^ gf_mul(8'h0D, $past(state_i[15:8]))
        ^ gf_mul(8'h09, $past(state_i[23:16])) ^ gf_mul(8'h0E, $past(state_i[31:24]))))
        else $error("inverse mix row 3 is wrong");

    // Forward mix followed by inverse mix returns the operand.
    a_mix_undo: assert property (s_take(OP_MIX_COLS) |=> mix_cols(result_o, 1'b1) == $past(state_i))
        else $error("inverse mix does not undo forward mix");

    // Inverse shift: row 0 column 0 fixed, row 1 column 0 takes column 3.
    a_ishift_rows: assert property (s_take(OP_INV_SHIFT_ROWS) |=>
        result_o[7:0] == $past(state_i[7:0]) && result_o[15:8] == $past(state_i[111:104]))
        else $error("inverse row shift is wrong");

    // Inverse shift: row 2 column 0 takes column 2, row 3 column 0 takes column 1.
    a_ishift_lower: assert property (s_take(OP_INV_SHIFT_ROWS) |=>
        result_o[23:16] == $past(state_i[87:80]) && result_o[31:24] == $past(state_i[63:56]))
        else $error("inverse row shift of rows 2 and 3 is wrong");

    // Zero in, all 52 out.
    a_isub_zero: assert property (s_take(OP_INV_SUB_BYTES) and state_i == '0 |=> result_o == {16{INV_SBOX_ZERO}})
        else $error("inverse substitution of zero is wrong");

    // Forward table of the inverse result gives back the operand.
    a_isub_undo: assert property (s_take(OP_INV_SUB_BYTES) |=> sub_all(result_o, 1'b0) == $past(state_i))
        else $error("inverse substitution does not undo forward");

    // Multiplying by one returns the operand in the low half.
    a_clmul_one: assert property (s_take(OP_CLMUL) and state_i[127:64] == 64'h1 |=>
        result_o == {64'h0, $past(state_i[63:0])})
        else $error("carry-less product by one is wrong");

    // Squaring x^63 gives x^126 with no reduction.
    a_clmul_top: assert property (s_take(OP_CLMUL) and state_i == {2{64'h8000_0000_0000_0000}} |=>
        result_o == 128'h4000_0000_0000_0000_0000_0000_0000_0000)
        else $error("carry-less product is reduced or truncated");

    // Both capability flags are set at all times.
    a_feature_bits: assert property (feature_o[FEAT_AES_BIT] && feature_o[FEAT_CLMUL_BIT])
        else $error("capability flags are missing");

    // A top bit multiplied by 02 wraps through the reduction polynomial.
    a_mix_reduce: assert property (s_take(OP_MIX_COLS) and state_i[31:0] == 32'h0000_0080 |=>
        result_o[31:0] == 32'h9B80_801B)
        else $error("field reduction is wrong");

    // Forward row 0 uses 02, 03, 01, 01.
    a_mix_row0: assert property (s_take(OP_MIX_COLS) |=> result_o[7:0] ==
        (gf_mul(8'h02, $past(state_i[7:0])) ^ gf_mul(8'h03, $past(state_i[15:8]))
        ^ $past(state_i[23:16]) ^ $past(state_i[31:24])))
        else $error("forward mix row 0 is wrong");

    // Forward row 3 uses 03, 01, 01, 02.
    a_mix_row3: assert property (s_take(OP_MIX_COLS) |=> result_o[31:24] ==
        (gf_mul(8'h03, $past(state_i[7:0])) ^ $past(state_i[15:8])
        ^ $past(state_i[23:16]) ^ gf_mul(8'h02, $past(state_i[31:24]))))
        else $error("forward mix row 3 is wrong");

    // Forward shift: row 1 column 0 takes column 1, row 3 column 0 takes column 3.
    a_shift_rows: assert property (s_take(OP_SHIFT_ROWS) |=>
        result_o[15:8] == $past(state_i[47:40]) && result_o[31:24] == $past(state_i[127:120]))
        else $error("forward row shift is wrong");

    // The forward row shift never moves a byte to another row.
    a_byte_rows: assert property (s_take(OP_SHIFT_ROWS) and state_i == {4{32'h0302_0100}} |=>
        result_o == {4{32'h0302_0100}})
        else $error("row shift moved bytes between rows");

    // The result appears exactly one cycle after the operand set, and only then.
    a_fixed_latency: assert property (valid_i |-> s_give)
        else $error("result missing after one cycle");
    a_no_spurious: assert property (!valid_i |=> !valid_o && $stable(result_o))
        else $error("result changed without an operand set");

endmodule

// ===== test/aesp_pipe_drv.sv
// Pipeline side that presents operand sets to the datapath.
module aesp_pipe_drv
    import aesp_pkg::*;
(
    // Clock.
    input  wire logic                         clock_i,
    // Operand set towards the datapath.
    output logic                              valid_o,
    output aesp_pkg::aesp_op_e                op_o,
    output logic      [aesp_pkg::STATE_W-1:0] state_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero.
    initial begin
        valid_o = 1'b0;
        op_o = OP_SUB_BYTES;
        state_o = 128'h0;
    end

    // one set per cycle.
    // Holds the set through one taking edge; callers enter just after an edge.
    task automatic send(input aesp_op_e op, input logic [127:0] st);
        valid_o = 1'b1;
        op_o = op;
        state_o = st;
        @(posedge clock_i);
        #1;
    endtask

    // Drops the strobe; the released operand keeps toggling so stale data is never trusted.
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            valid_o = 1'b0;
            state_o = ~state_o;
            @(posedge clock_i);
            #1;
        end
    endtask
endmodule

// ===== test/tb.sv
// Self-checking bench for the round primitives.
module tb;
    import aesp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clock_i;
    logic             reset_n_i;
    logic             valid_i;
    aesp_op_e         op_i;
    logic     [127:0] state_i;
    logic             valid_o;
    logic     [127:0] result_o;
    logic     [31:0]  feature_o;
    int               num_errors;
    int               n_checks;
    logic             taken_q;
    logic     [127:0] exp_q[$];
    bit               chk_q[$];
    logic     [127:0] got_q[$];

    // Free-running core clock.
    initial clock_i = 1'b0;
    always #5 clock_i = ~clock_i;

    aesp_pipe_drv i_drv (.clock_i(clock_i), .valid_o(valid_i), .op_o(op_i), .state_o(state_i));

    aesp_round_prims i_dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .valid_i(valid_i), .op_i(op_i),
        .state_i(state_i), .valid_o(valid_o), .result_o(result_o), .feature_o(feature_o));

    function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) r ^= a;
            a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
        end
        return r;
    endfunction

    // rotated coefficients.
    // Column mix; byte i of c multiplies the diagonal row plus i.
    function automatic logic [127:0] mix(input logic [127:0] s, input logic [31:0] c);
        logic [127:0] o;
        o = 128'h0;
        for (int k = 0; k < 16; k++)
            for (int i = 0; i < 4; i++)
                o[8*k+:8] ^= gm(c[8*((i-k%4+4)%4)+:8], s[8*(k/4*4+i)+:8]);
        return o;
    endfunction

    // byte to cell.
    // Row shift; d is 1 for left, -1 for right.
    function automatic logic [127:0] shf(input logic [127:0] s, input int d);
        logic [127:0] o;
        for (int k = 0; k < 16; k++)
            o[8*k+:8] = s[8*(((k/4+d*(k%4)+16)%4)*4+k%4)+:8];
        return o;
    endfunction

    function automatic logic [127:0] clm(input logic [63:0] a, input logic [63:0] b);
        logic [127:0] r;
        r = 128'h0;
        for (int i = 0; i < 64; i++) if (b[i]) r ^= {64'h0, a} << i;
        return r;
    endfunction

    // Expected result of the table-free operations.
    function automatic logic [127:0] model(input aesp_op_e op, input logic [127:0] s);
        case (op)
            OP_SHIFT_ROWS:     return shf(s, 1);
            OP_INV_SHIFT_ROWS: return shf(s, -1);
            OP_MIX_COLS:       return mix(s, 32'h0101_0302);
            OP_INV_MIX_COLS:   return mix(s, 32'h090D_0B0E);
            default:           return clm(s[63:0], s[127:64]);
        endcase
    endfunction

    function automatic logic [127:0] rnd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    task automatic cmp(input string name, input logic [127:0] e, input logic [127:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    // Queues the expectation, then hands the set to the pipeline model.
    task automatic run(input aesp_op_e op, input logic [127:0] st, input logic [127:0] e, input bit chk);
        exp_q.push_back(e);
        chk_q.push_back(chk);
        i_drv.send(op, st);
    endtask

    // Waits a bounded time for all outstanding results.
    task automatic drain();
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) i_drv.idle(1);
        cmp("pending", 128'h0, 128'(exp_q.size()));
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Result monitor: one valid pulse one cycle after each taken set; reset flushes.
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            taken_q <= 1'b0;
            exp_q.delete();
            chk_q.delete();
        end else begin
            cmp("valid_o", {127'h0, taken_q}, {127'h0, valid_o});
            if (valid_o === 1'b1 && exp_q.size() > 0) begin
                got_q.push_back(result_o);
                if (chk_q.pop_front()) cmp("result_o", exp_q.pop_front(), result_o);
                else void'(exp_q.pop_front());
            end
            taken_q <= valid_i;
        end
    end

    // Hang guard, well beyond the expected run.
    initial begin
        #100000;
        num_errors++;
        $display("Error watchdog expected finish seen timeout");
        complete_run();
    end

    // Main sequence.
    initial begin
        logic     [127:0] t;
        logic     [127:0] a;
        logic     [127:0] b;
        logic     [255:0] w;
        logic     [255:0] e;
        aesp_op_e         ops[5];
        ops = '{OP_SHIFT_ROWS, OP_INV_SHIFT_ROWS, OP_MIX_COLS, OP_INV_MIX_COLS, OP_CLMUL};
        reset_n_i = 1'b0;
        num_errors = 0;
        n_checks = 0;
        void'($urandom(37));
        repeat (10) @(posedge clock_i);
        cmp("reset result_o", 128'h0, result_o);
        cmp("feature_o", 128'h0200_0002, {96'h0, feature_o});
        cmp("feature flags", 128'h3, {126'h0, feature_o[25], feature_o[1]});
        #1;
        reset_n_i = 1'b1;
        $display("test reset done");
        t = 128'hFFEEDDCC_BBAA9988_77665544_33221100;
        a = 128'h1628C14B_EAACEEC4_F533FC1B_C3938263;
        run(OP_SUB_BYTES, t, a, 1);
        run(OP_INV_SUB_BYTES, a, t, 1);
        run(OP_INV_SUB_BYTES, 128'h0, {16{8'h52}}, 1);
        run(OP_SUB_WORD, (rnd() << 32) | 128'hFFEE_DDCC, 128'h1628C14B, 1);
        drain();
        $display("test tables done");
        got_q.delete();
        for (int k = 0; k < 16; k++) begin
            for (int j = 0; j < 16; j++) t[8*j+:8] = 8'(16*k+j);
            run(OP_SUB_BYTES, t, 128'h0, 0);
        end
        drain();
        for (int k = 0; k < 16; k++) begin
            for (int j = 0; j < 16; j++) t[8*j+:8] = 8'(16*k+j);
            run(OP_INV_SUB_BYTES, got_q[k], t, 1);
        end
        drain();
        $display("test round trip done");
        for (int n = 0; n < 60; n++) begin
            t = rnd();
            run(ops[n%5], t, model(ops[n%5], t), 1);
            if ($urandom % 4 == 0) i_drv.idle(1 + $urandom % 3);
        end
        t = (rnd() << 32) | 128'h80;
        run(OP_MIX_COLS, t, model(OP_MIX_COLS, t), 1);
        t = (128'h1 << 64) | (rnd() >> 64);
        run(OP_CLMUL, t, model(OP_CLMUL, t), 1);
        run(OP_CLMUL, {2{64'h8000_0000_0000_0000}}, 128'h4000_0000_0000_0000_0000_0000_0000_0000, 1);
        run(OP_SHIFT_ROWS, {4{32'h0302_0100}}, {4{32'h0302_0100}}, 1);
        drain();
        got_q.delete();
        t = rnd();
        run(OP_MIX_COLS, t, model(OP_MIX_COLS, t), 1);
        drain();
        run(OP_INV_MIX_COLS, got_q[0], t, 1);
        drain();
        $display("test random ops done");
        a = rnd();
        b = rnd();
        got_q.delete();
        for (int i = 0; i < 4; i++) run(OP_CLMUL, {b[64*(i%2)+:64], a[64*(i/2)+:64]}, 128'h0, 0);
        drain();
        w = {128'h0, got_q[0]} ^ ({128'h0, got_q[1]} << 64) ^ ({128'h0, got_q[2]} << 64) ^ ({128'h0, got_q[3]} << 128);
        e = 256'h0;
        for (int i = 0; i < 128; i++) if (b[i]) e ^= {128'h0, a} << i;
        cmp("wide low", e[127:0], w[127:0]);
        cmp("wide high", e[255:128], w[255:128]);
        $display("test wide product done");
        run(OP_SUB_BYTES, 128'h0, 128'h0, 0);
        reset_n_i = 1'b0;
        i_drv.idle(2);
        cmp("mid reset valid_o", 128'h0, {127'h0, valid_o});
        cmp("mid reset result_o", 128'h0, result_o);
        reset_n_i = 1'b1;
        i_drv.idle(2);
        run(OP_SUB_BYTES, 128'h0, {16{8'h63}}, 1);
        drain();
        $display("test mid reset done");
        complete_run();
    end
endmodule
